// ==== tmrb_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmrb_host_model (
    input wire logic clock,
    input wire logic [7:0] rd_data,
    output var tmrb_pkg::tmrb_bus_t bus
);
    initial bus = '0;
    // Each byte is a one-cycle pulse; an idle cycle follows so no signal moves twice at once.
    task automatic put(input logic first, input logic [7:0] d);
        @(negedge clock);
        bus.wr_valid = 1'b1;
        bus.first_byte = first;
        bus.wr_data = d;
        @(negedge clock);
        bus = '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, a);
        put(1'b0, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        put(1'b1, a);
        @(negedge clock);
        v = rd_data;
        bus.rd_strobe = 1'b1;
        @(negedge clock);
        bus.rd_strobe = 1'b0;
    endtask
    task automatic ara();
        @(negedge clock);
        bus.ara_strobe = 1'b1;
        @(negedge clock);
        bus.ara_strobe = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tmrb_pkg.sv ====
package tmrb_pkg;
    localparam logic [7:0] RD_LOCAL_TEMP = 8'h00;
    localparam logic [7:0] RD_REMOTE_TEMP = 8'h01;
    localparam logic [7:0] RD_STATUS = 8'h02;
    localparam logic [7:0] RD_CONFIG = 8'h03;
    localparam logic [7:0] RD_RATE = 8'h04;
    localparam logic [7:0] RD_LOCAL_HI = 8'h05;
    localparam logic [7:0] RD_LOCAL_LO = 8'h06;
    localparam logic [7:0] RD_REMOTE_HI = 8'h07;
    localparam logic [7:0] RD_REMOTE_LO = 8'h08;
    localparam logic [7:0] RD_OFFSET = 8'h11;
    localparam logic [7:0] RD_MAKER_ID = 8'hFE;
    localparam logic [7:0] RD_REVISION = 8'hFF;
    localparam logic [7:0] WR_CONFIG = 8'h09;
    localparam logic [7:0] WR_RATE = 8'h0A;
    localparam logic [7:0] WR_LOCAL_HI = 8'h0B;
    localparam logic [7:0] WR_LOCAL_LO = 8'h0C;
    localparam logic [7:0] WR_REMOTE_HI = 8'h0D;
    localparam logic [7:0] WR_REMOTE_LO = 8'h0E;
    localparam logic [7:0] WR_ONE_SHOT = 8'h0F;
    localparam logic [7:0] WR_OFFSET = 8'h11;
    localparam logic [7:0] RST_TEMP = 8'h80;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h02;
    localparam logic [7:0] RST_HI_LIMIT = 8'h7F;
    localparam logic [7:0] RST_LO_LIMIT = 8'hC9;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam int BIT_BUSY = 7;
    localparam int BIT_LOCAL_OVER = 6;
    localparam int BIT_LOCAL_UNDER = 5;
    localparam int BIT_REMOTE_OVER = 4;
    localparam int BIT_REMOTE_UNDER = 3;
    localparam int BIT_OPEN = 2;
    localparam int BIT_MASK = 7;
    localparam int BIT_STANDBY = 6;
    localparam logic [7:0] CONFIG_USED = 8'hC0;
    localparam logic [7:0] RATE_USED = 8'h07;
    localparam int RATE_FASTEST_MS = 125;
    localparam int CLOCK_MHZ = 100;
    localparam int FASTEST_PERIOD_CYCLES = RATE_FASTEST_MS * 1000 * CLOCK_MHZ;
    localparam int CONVERT_CYCLES = 16;
    localparam logic [7:0] MAKER_ID_VALUE = 8'h5A;
    localparam logic [7:0] REVISION_VALUE = 8'h01;

    typedef enum logic [1:0] {
        TMRB_IDLE = 2'b00,
        TMRB_CONVERT = 2'b01,
        TMRB_STANDBY = 2'b10
    } tmrb_mode_t;

    typedef struct packed {
        logic wr_valid;
        logic first_byte;
        logic [7:0] wr_data;
        logic rd_strobe;
        logic ara_strobe;
    } tmrb_bus_t;

    typedef struct packed {
        logic [7:0] local_temp;
        logic [7:0] remote_temp;
        logic open_circuit;
    } tmrb_meas_t;

    typedef struct packed {
        tmrb_mode_t mode;
        logic [7:0] pointer;
        logic [7:0] local_temp_value;
        logic [7:0] remote_temp_value;
        logic [4:0] flags;
        logic alert_latch;
        logic [7:0] device_configuration;
        logic [7:0] conversion_rate_select;
        logic [7:0] local_upper_limit;
        logic [7:0] local_lower_limit;
        logic [7:0] remote_upper_limit;
        logic [7:0] remote_lower_limit;
        logic [7:0] remote_temp_offset;
        logic one_shot;
        logic [7:0] rd_data;
        logic alert_n;
        logic busy;
        logic [31:0] period_count;
        logic [4:0] conv_count;
        logic standby_pin_n_meta;
        logic standby_pin_n_sync;
    } tmrb_state_t;
endpackage

// ==== tmrb_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmrb_props (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire tmrb_pkg::tmrb_bus_t bus,
    input wire tmrb_pkg::tmrb_meas_t meas,
    input wire logic standby_pin_n,
    input wire logic [7:0] rd_data,
    input wire logic alert_n,
    input wire logic busy
);
    // Shadow pointer, so read checks know which register is selected.
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    always_comb begin
        ptr_next = ptr_reg;
        if (clk_en && bus.wr_valid && bus.first_byte) begin
            ptr_next = bus.wr_data;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ptr_reg <= 8'h00;
        end else begin
            ptr_reg <= ptr_next;
        end
    end
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    property p_busy_len;
        $rose(busy) |-> busy[*8] ##1 busy[*8] ##1 !busy;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy width wrong");
    property p_stat_rsv;
        ptr_reg == 8'h02 && $past(ptr_reg) == 8'h02 |-> rd_data[1:0] == 2'b00;
    endproperty
    a_stat_rsv: assert property (p_stat_rsv) else $error("status low bits set");
    property p_cfg_rsv;
        ptr_reg == 8'h03 && $past(ptr_reg) == 8'h03 |-> rd_data[5:0] == 6'h00;
    endproperty
    a_cfg_rsv: assert property (p_cfg_rsv) else $error("config low bits set");
    property p_unmapped;
        ptr_reg == 8'h10 && $past(ptr_reg) == 8'h10 |-> rd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_shot_rd;
        ptr_reg == 8'h0F && $past(ptr_reg) == 8'h0F |-> rd_data == 8'h00;
    endproperty
    a_shot_rd: assert property (p_shot_rd) else $error("trigger address readable");
    property p_shot_go;
        bus.wr_valid && !bus.first_byte && ptr_reg == 8'h0F |-> ##[1:4] busy;
    endproperty
    a_shot_go: assert property (p_shot_go) else $error("trigger gave no conversion");
    property p_alert_rel;
        $rose(alert_n) |-> $past(bus.ara_strobe, 2) || $past(bus.ara_strobe)
            || $past(bus.wr_valid, 2) || $past(bus.wr_valid);
    endproperty
    a_alert_rel: assert property (p_alert_rel) else $error("alert released alone");
    property p_standby_pin_n;
        (!standby_pin_n && !bus.wr_valid)[*8] |-> !$rose(busy);
    endproperty
    a_standby_pin_n: assert property (p_standby_pin_n) else $error("conversion in standby");
endmodule
bind tmrb_register_bank tmrb_props u_props (.clock(clock), .rstn(rstn), .clk_en(clk_en),
    .bus(bus), .meas(meas), .standby_pin_n(standby_pin_n), .rd_data(rd_data),
    .alert_n(alert_n), .busy(busy));
`default_nettype wire

// ==== tmrb_register_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmrb_register_bank #(
    parameter int unsigned FASTEST_PERIOD = tmrb_pkg::FASTEST_PERIOD_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire tmrb_pkg::tmrb_bus_t bus,
    input wire tmrb_pkg::tmrb_meas_t meas,
    input wire logic standby_pin_n,
    output logic [7:0] rd_data,
    output logic alert_n,
    output logic busy
);
    tmrb_pkg::tmrb_state_t s_reg;
    tmrb_pkg::tmrb_state_t s_next;

    function automatic logic over(input logic [7:0] value, input logic [7:0] limit);
        over = $signed(value) > $signed(limit);
    endfunction

    function automatic logic under(input logic [7:0] value, input logic [7:0] limit);
        under = $signed(value) < $signed(limit);
    endfunction

    logic [4:0] trip;
    logic standby;
    logic [31:0] period_len;
    logic [7:0] status_byte;

    always_comb begin
        // Comparisons use the stored values, so a frozen reading keeps its fault.
        trip[4] = over(s_reg.local_temp_value, s_reg.local_upper_limit);
        trip[3] = under(s_reg.local_temp_value, s_reg.local_lower_limit);
        trip[2] = over(s_reg.remote_temp_value, s_reg.remote_upper_limit);
        trip[1] = under(s_reg.remote_temp_value, s_reg.remote_lower_limit);
        trip[0] = meas.open_circuit;
        standby = s_reg.device_configuration[tmrb_pkg::BIT_STANDBY] | ~s_reg.standby_pin_n_sync;
        period_len = FASTEST_PERIOD << (3'd7 - s_reg.conversion_rate_select[2:0]);
        status_byte = {s_reg.busy, s_reg.flags, 2'b00};
    end

    always_comb begin
        s_next = s_reg;
        s_next.standby_pin_n_meta = standby_pin_n;
        s_next.standby_pin_n_sync = s_reg.standby_pin_n_meta;
        // Hardware setting wins over the read clear within the same cycle.
        s_next.flags = s_reg.flags | trip;
        if (bus.rd_strobe && s_reg.pointer == tmrb_pkg::RD_STATUS) begin
            s_next.flags = trip;
        end
        if (|s_reg.flags) begin
            s_next.alert_latch = 1'b1;
        end else if (bus.ara_strobe && trip == 5'b00000) begin
            s_next.alert_latch = 1'b0;
        end
        if (bus.wr_valid) begin
            if (bus.first_byte) begin
                s_next.pointer = bus.wr_data;
            end else begin
                unique case (s_reg.pointer)
                    tmrb_pkg::WR_CONFIG: begin
                        s_next.device_configuration = bus.wr_data & tmrb_pkg::CONFIG_USED;
                    end
                    tmrb_pkg::WR_RATE: begin
                        s_next.conversion_rate_select = bus.wr_data;
                    end
                    tmrb_pkg::WR_LOCAL_HI: s_next.local_upper_limit = bus.wr_data;
                    tmrb_pkg::WR_LOCAL_LO: s_next.local_lower_limit = bus.wr_data;
                    tmrb_pkg::WR_REMOTE_HI: s_next.remote_upper_limit = bus.wr_data;
                    tmrb_pkg::WR_REMOTE_LO: s_next.remote_lower_limit = bus.wr_data;
                    tmrb_pkg::WR_ONE_SHOT: s_next.one_shot = 1'b1;
                    tmrb_pkg::WR_OFFSET: s_next.remote_temp_offset = bus.wr_data;
                    default: begin
                    end
                endcase
            end
        end
        unique case (s_reg.pointer)
            tmrb_pkg::RD_LOCAL_TEMP: s_next.rd_data = s_reg.local_temp_value;
            tmrb_pkg::RD_REMOTE_TEMP: s_next.rd_data = s_reg.remote_temp_value;
            tmrb_pkg::RD_STATUS: s_next.rd_data = status_byte;
            tmrb_pkg::RD_CONFIG: s_next.rd_data = s_reg.device_configuration;
            tmrb_pkg::RD_RATE: s_next.rd_data = s_reg.conversion_rate_select;
            tmrb_pkg::RD_LOCAL_HI: s_next.rd_data = s_reg.local_upper_limit;
            tmrb_pkg::RD_LOCAL_LO: s_next.rd_data = s_reg.local_lower_limit;
            tmrb_pkg::RD_REMOTE_HI: s_next.rd_data = s_reg.remote_upper_limit;
            tmrb_pkg::RD_REMOTE_LO: s_next.rd_data = s_reg.remote_lower_limit;
            tmrb_pkg::RD_OFFSET: s_next.rd_data = s_reg.remote_temp_offset;
            tmrb_pkg::RD_MAKER_ID: s_next.rd_data = tmrb_pkg::MAKER_ID_VALUE;
            tmrb_pkg::RD_REVISION: s_next.rd_data = tmrb_pkg::REVISION_VALUE;
            default: s_next.rd_data = 8'h00;
        endcase
        unique case (s_reg.mode)
            tmrb_pkg::TMRB_IDLE: begin
                s_next.period_count = s_reg.period_count + 32'h00000001;
                if (s_reg.one_shot || (!standby && s_reg.period_count + 32'h00000001 >= period_len)) begin
                    s_next.mode = tmrb_pkg::TMRB_CONVERT;
                    s_next.one_shot = 1'b0;
                    s_next.conv_count = 5'h00;
                    s_next.period_count = 32'h00000000;
                    s_next.busy = 1'b1;
                end else if (standby) begin
                    s_next.mode = tmrb_pkg::TMRB_STANDBY;
                end
            end
            tmrb_pkg::TMRB_CONVERT: begin
                // The period runs on through the conversion, so starts are one period apart.
                s_next.period_count = s_reg.period_count + 32'h00000001;
                s_next.conv_count = s_reg.conv_count + 5'h01;
                if (s_reg.conv_count == 5'(tmrb_pkg::CONVERT_CYCLES - 1)) begin
                    s_next.local_temp_value = meas.local_temp;
                    s_next.remote_temp_value = meas.remote_temp;
                    s_next.busy = 1'b0;
                    s_next.mode = tmrb_pkg::TMRB_IDLE;
                end
            end
            tmrb_pkg::TMRB_STANDBY: begin
                // Values are not written here, so the last reading stays put.
                s_next.period_count = 32'h00000000;
                if (s_reg.one_shot) begin
                    s_next.mode = tmrb_pkg::TMRB_CONVERT;
                    s_next.one_shot = 1'b0;
                    s_next.conv_count = 5'h00;
                    s_next.busy = 1'b1;
                end else if (!standby) begin
                    s_next.mode = tmrb_pkg::TMRB_IDLE;
                end
            end
            default: s_next.mode = tmrb_pkg::TMRB_IDLE;
        endcase
        s_next.alert_n = ~(s_reg.alert_latch & ~s_reg.device_configuration[tmrb_pkg::BIT_MASK]);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '{
                mode: tmrb_pkg::TMRB_IDLE,
                pointer: 8'h00,
                local_temp_value: tmrb_pkg::RST_TEMP,
                remote_temp_value: tmrb_pkg::RST_TEMP,
                flags: 5'h00,
                alert_latch: 1'b0,
                device_configuration: tmrb_pkg::RST_CONFIG,
                conversion_rate_select: tmrb_pkg::RST_RATE,
                local_upper_limit: tmrb_pkg::RST_HI_LIMIT,
                local_lower_limit: tmrb_pkg::RST_LO_LIMIT,
                remote_upper_limit: tmrb_pkg::RST_HI_LIMIT,
                remote_lower_limit: tmrb_pkg::RST_LO_LIMIT,
                remote_temp_offset: tmrb_pkg::RST_OFFSET,
                one_shot: 1'b0,
                rd_data: 8'h00,
                alert_n: 1'b1,
                busy: 1'b0,
                period_count: 32'h00000000,
                conv_count: 5'h00,
                standby_pin_n_meta: 1'b1,
                standby_pin_n_sync: 1'b1
            };
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign rd_data = s_reg.rd_data;
    assign alert_n = s_reg.alert_n;
    assign busy = s_reg.busy;
endmodule
`default_nettype wire

// ==== tmrb_register_bank_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end
module tmrb_register_bank_tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic standby_pin_n = 1'b0;
    tmrb_pkg::tmrb_meas_t meas = '0;
    tmrb_pkg::tmrb_bus_t bus;
    logic [7:0] rd_data;
    logic alert_n;
    logic busy;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 clock = ~clock;
    tmrb_host_model host (.clock(clock), .rd_data(rd_data), .bus(bus));
    tmrb_register_bank #(.FASTEST_PERIOD(20)) dut (.clock(clock), .rstn(rstn), .clk_en(1'b1),
        .bus(bus), .meas(meas), .standby_pin_n(standby_pin_n), .rd_data(rd_data),
        .alert_n(alert_n), .busy(busy));
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        `CHK($sformatf("register %h", a), e, v & m)
    endtask
    task automatic wait_busy(input logic level, output int n);
        n = 0;
        while (busy !== level && n < 200) begin
            @(negedge clock);
            n++;
        end
        `CHK("busy", level, busy)
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        logic [7:0] rst_tab [0:8];
        int n1;
        int n2;
        rst_tab = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9};
        repeat (3) @(negedge clock);
        rstn = 1'b1;
        for (int i = 0; i < 9; i++) begin
            if (i != 2) begin
                chk(8'(i), 8'hFF, rst_tab[i]);
            end
        end
        chk(tmrb_pkg::RD_OFFSET, 8'hFF, 8'h00);
        chk(tmrb_pkg::RD_MAKER_ID, 8'hFF, tmrb_pkg::MAKER_ID_VALUE);
        host.wr(tmrb_pkg::WR_LOCAL_LO, 8'hF6);
        chk(tmrb_pkg::RD_LOCAL_LO, 8'hFF, 8'hF6);
        host.wr(tmrb_pkg::WR_CONFIG, 8'hFF);
        chk(tmrb_pkg::RD_CONFIG, 8'hFF, 8'hC0);
        host.wr(tmrb_pkg::RD_LOCAL_TEMP, 8'h55);
        chk(tmrb_pkg::RD_LOCAL_TEMP, 8'hFF, 8'h80);
        chk(tmrb_pkg::WR_LOCAL_HI, 8'hFF, 8'h00);
        chk(8'h10, 8'hFF, 8'h00);
        host.wr(tmrb_pkg::WR_LOCAL_HI, 8'h10);
        host.wr(tmrb_pkg::WR_REMOTE_HI, 8'h05);
        host.wr(tmrb_pkg::WR_REMOTE_LO, 8'h05);
        meas = '{local_temp: 8'h14, remote_temp: 8'h05, open_circuit: 1'b0};
        host.wr(tmrb_pkg::WR_ONE_SHOT, 8'hAA);
        wait_busy(1'b1, n1);
        wait_busy(1'b0, n1);
        chk(tmrb_pkg::RD_LOCAL_TEMP, 8'hFF, 8'h14);
        chk(tmrb_pkg::RD_REMOTE_TEMP, 8'hFF, 8'h05);
        `CHK("alert_n", 1'b1, alert_n)
        chk(tmrb_pkg::RD_STATUS, 8'hFF, 8'h68);
        host.wr(tmrb_pkg::WR_CONFIG, 8'h00);
        repeat (3) @(negedge clock);
        `CHK("alert_n", 1'b0, alert_n)
        chk(tmrb_pkg::RD_STATUS, 8'hFF, 8'h40);
        host.wr(tmrb_pkg::WR_LOCAL_HI, 8'h7F);
        chk(tmrb_pkg::RD_STATUS, 8'hFF, 8'h40);
        chk(tmrb_pkg::RD_STATUS, 8'hFF, 8'h00);
        `CHK("alert_n", 1'b0, alert_n)
        host.ara();
        repeat (3) @(negedge clock);
        `CHK("alert_n", 1'b1, alert_n)
        host.wr(tmrb_pkg::WR_RATE, 8'h07);
        meas.local_temp = 8'h30;
        chk(tmrb_pkg::RD_LOCAL_TEMP, 8'hFF, 8'h14);
        standby_pin_n = 1'b1;
        wait_busy(1'b1, n1);
        wait_busy(1'b0, n1);
        wait_busy(1'b1, n2);
        `CHK("period", 20, n1 + n2)
        wait_busy(1'b0, n1);
        chk(tmrb_pkg::RD_LOCAL_TEMP, 8'hFF, 8'h30);
        standby_pin_n = 1'b0;
        meas.open_circuit = 1'b1;
        repeat (30) @(negedge clock);
        chk(tmrb_pkg::RD_STATUS, 8'h7F, 8'h04);
        test_done();
    end
endmodule
`default_nettype wire
